// File: inc/pafm_cfg.svh
`ifndef PAFM_CFG_SVH
`define PAFM_CFG_SVH

// pad count and pad index of every muxed pad
`define PAFM_NUM_PADS    8
`define PAFM_PAD_PA0     0
`define PAFM_PAD_PA4     1
`define PAFM_PAD_PORTA_LINE13    2
`define PAFM_PAD_PORTA_LINE14    3
`define PAFM_PAD_PB8     4
`define PAFM_PAD_PORTB_LINE12    5
`define PAFM_PAD_PORTC_LINE13    6
`define PAFM_PAD_PF0     7

// selector field: width, plain port code, reset value
`define PAFM_SEL_W       3
`define PAFM_SEL_PLAIN   3'h0
`define PAFM_SEL_RESET   3'h0

// peripheral signal index space; the top code marks an unassigned slot
`define PAFM_NUM_PERIPH  31
`define PAFM_IDX_W       5
`define PAFM_IDX_NONE    5'h1f

`endif

// File: inc/pafm_pkg.sv
package pafm_pkg;

    // one index per on-chip peripheral signal that reaches a muxed pad
    typedef enum logic [4:0] {
        P_S3_CTS   = 5'h00,  // serial3_clear_to_send
        P_S2_CTS   = 5'h01,  // serial2_clear_to_send
        P_TAMPER   = 5'h02,  // calendar_tamper_in
        P_CMP1     = 5'h03,  // comparator1_result
        P_GT2_CH1  = 5'h04,  // gp_timer2_channel1
        P_GT2_ETR  = 5'h05,  // gp_timer2_external_trigger
        P_MON_CLK  = 5'h06,  // clock_monitor_output
        P_BUS_CLK  = 5'h07,  // bus clock output
        P_SPI_CS   = 5'h08,  // spi chip select
        P_ADV_CH2A = 5'h09,  // adv_timer_channel2a
        P_TWI_SDA  = 5'h0a,  // two-wire data
        P_S1_RX    = 5'h0b,  // serial1_receive
        P_S2_TX    = 5'h0c,  // serial2_transmit
        P_INFRARED_OUTPUT   = 5'h0d,  // infrared_output
        P_S3_TX    = 5'h0e,  // serial3_transmit
        P_TWI_SCL  = 5'h0f,  // two-wire clock
        P_S1_TX    = 5'h10,  // serial1_transmit
        P_S2_RX    = 5'h11,  // serial2_receive
        P_GT1_CH3  = 5'h12,  // gp_timer1_channel3
        P_ADV_ETR  = 5'h13,  // adv_timer_external_trigger
        P_ONE_HZ   = 5'h14,  // calendar_one_hertz_out
        P_S1_CTS   = 5'h15,  // serial1_clear_to_send
        P_CAL_EVT  = 5'h16,  // calendar event output
        P_BT_TRIG  = 5'h17,  // basic_timer_trigger_in
        P_GT2_TOGP = 5'h18,  // gp_timer2_positive_toggle
        P_LSC_OUT  = 5'h19,  // low_speed_crystal_clock_output
        P_GT1_TOGP = 5'h1a,  // gp_timer1_positive_toggle
        P_ADV_BRK  = 5'h1b,  // adv_timer_break_in
        P_WUT_TRIG = 5'h1c,  // wakeup_timer_trigger_in
        P_BT1_TOGN = 5'h1d,  // basic_timer1_negative_toggle
        P_S3_RX    = 5'h1e,  // serial3_receive
        P_NONE     = 5'h1f   // unassigned slot
    } pafm_periph_t;

endpackage

// File: hdl/pafm_mux.sv
// Overview of operation
// R01: unexempted pads reset to high-impedance inputs
// R02: debug pads reset as debug pins, pulled up; pad_pu_o stays low until the first clock after reset
// R03: digital peripherals reach pads only via selectors
// R04: analog connection follows peripheral enable, not selector
// R05: reset function is the plain port line
// R06: each port offers selectors one through seven
// R07: porta_line0 slot map
// R08: porta_line13 debug data pad slot map
// R09: porta_line14 debug clock pad slot map
// R10: portb_line8 slot map
// R11: portc_line13 slot map
// R12: porta_line4 slot map
// R13: portb_line12 slot map
// R14: portf_line0 slot map
// R15: boot pad is input only, no selector
// R16: radio aux line: input, or amplifier enable
// R17: unassigned slot: no peripheral, output disabled
// R18: inputs forward pad level, outputs drive pad
`timescale 1ns/100ps
`include "pafm_cfg.svh"

module pafm_mux
    import pafm_pkg::*;
(
    input  wire logic                                      ref_clk_i,
    input  wire logic                                      nrst_i,
    input  wire logic [`PAFM_NUM_PADS-1:0]                 sel_we_i,
    input  wire logic [`PAFM_NUM_PADS*`PAFM_SEL_W-1:0]     sel_wdata_i,
    output logic      [`PAFM_NUM_PADS*`PAFM_SEL_W-1:0]     sel_o,
    input  wire logic [`PAFM_NUM_PADS-1:0]                 gpio_out_i,
    input  wire logic [`PAFM_NUM_PADS-1:0]                 gpio_oe_i,
    input  wire logic [`PAFM_NUM_PADS-1:0]                 gpio_pu_i,
    output logic      [`PAFM_NUM_PADS-1:0]                 gpio_in_o,
    input  wire logic                                      dbg_dio_out_i,
    input  wire logic                                      dbg_dio_oe_i,
    output logic                                           dbg_dio_in_o,
    output logic                                           dbg_clk_o,
    input  wire logic [`PAFM_NUM_PERIPH-1:0]               periph_out_i,
    input  wire logic [`PAFM_NUM_PERIPH-1:0]               periph_oe_i,
    output logic      [`PAFM_NUM_PERIPH-1:0]               periph_in_o,
    input  wire logic [`PAFM_NUM_PADS-1:0]                 pad_in_i,
    output logic      [`PAFM_NUM_PADS-1:0]                 pad_out_o,
    output logic      [`PAFM_NUM_PADS-1:0]                 pad_oe_o,
    output logic      [`PAFM_NUM_PADS-1:0]                 pad_pu_o,
    input  wire logic [`PAFM_NUM_PADS-1:0]                 analog_enable_i,
    output logic      [`PAFM_NUM_PADS-1:0]                 analog_connect_o,
    input  wire logic                                      boot_pad_i,
    output logic                                           boot_select_o,
    input  wire logic                                      radio_aux_in_i,
    input  wire logic                                      radio_aux_dir_i,
    input  wire logic                                      radio_pa_enable_i,
    output logic                                           radio_aux_data_o,
    output logic                                           radio_aux_out_o,
    output logic                                           radio_aux_oe_o
);

    localparam int NP = `PAFM_NUM_PADS;
    localparam int NK = `PAFM_NUM_PERIPH;

    // slot map: pad index and selector value to peripheral index
    function automatic logic [`PAFM_IDX_W-1:0] route(input logic [2:0] pad,
                                                     input logic [`PAFM_SEL_W-1:0] sel);
        logic [`PAFM_IDX_W-1:0] r;
        r = P_NONE;
        unique case (pad)
            3'h0: case (sel)                                   // R07
                3'h1: r = P_S3_CTS;
                3'h2: r = P_S2_CTS;
                3'h3: r = P_TAMPER;
                3'h4: r = P_CMP1;
                3'h6: r = P_GT2_CH1;
                3'h7: r = P_GT2_ETR;
                default: r = P_NONE;
            endcase
            3'h1: case (sel)                                   // R12
                3'h1: r = P_MON_CLK;
                3'h2: r = P_S2_CTS;
                3'h4: r = P_BUS_CLK;
                3'h5: r = P_SPI_CS;
                3'h6: r = P_GT2_ETR;
                3'h7: r = P_ADV_CH2A;
                default: r = P_NONE;
            endcase
            3'h2: case (sel)                                   // R08
                3'h2: r = P_TWI_SDA;
                3'h3: r = P_S1_RX;
                3'h4: r = P_S2_TX;
                3'h6: r = P_INFRARED_OUTPUT;
                default: r = P_NONE;
            endcase
            3'h3: case (sel)                                   // R09
                3'h1: r = P_S3_TX;
                3'h2: r = P_TWI_SCL;
                3'h3: r = P_S1_TX;
                3'h4: r = P_S2_RX;
                default: r = P_NONE;
            endcase
            3'h4: case (sel)                                   // R10
                3'h1: r = P_TWI_SCL;
                3'h2: r = P_S1_RX;
                3'h3: r = P_S1_TX;
                3'h6: r = P_GT1_CH3;
                3'h7: r = P_ADV_ETR;
                default: r = P_NONE;
            endcase
            3'h5: case (sel)                                   // R13
                3'h1: r = P_GT2_TOGP;
                3'h3: r = P_LSC_OUT;
                3'h5: r = P_SPI_CS;
                3'h6: r = P_GT1_TOGP;
                3'h7: r = P_ADV_BRK;
                default: r = P_NONE;
            endcase
            3'h6: case (sel)                                   // R11
                3'h1: r = P_S1_TX;
                3'h2: r = P_ONE_HZ;
                3'h3: r = P_S1_CTS;
                3'h4: r = P_CAL_EVT;
                3'h5: r = P_BT_TRIG;
                3'h7: r = P_TAMPER;
                default: r = P_NONE;
            endcase
            3'h7: case (sel)                                   // R14
                3'h1: r = P_WUT_TRIG;
                3'h2: r = P_S3_TX;
                3'h3: r = P_TWI_SDA;
                3'h4: r = P_BT1_TOGN;
                3'h5: r = P_S3_RX;
                3'h6: r = P_GT2_TOGP;
                default: r = P_NONE;
            endcase
        endcase
        return r;
    endfunction

    // per-pad selector registers, one field per pad
    logic [NP-1:0][`PAFM_SEL_W-1:0] sel_r;
    logic [NP-1:0]                  pad_out_nxt;   // next pad data
    logic [NP-1:0]                  pad_oe_nxt;    // next pad drive enable
    logic [NP-1:0]                  pad_pu_nxt;    // next pull-up request
    logic [NP-1:0]                  plain_w;       // pad in plain port mode
    logic [NP-1:0]                  none_w;        // selected slot is unassigned
    logic [`PAFM_IDX_W-1:0]         idx_w [NP];    // decoded peripheral per pad
    logic [NK-1:0]                  periph_in_nxt; // next level seen by peripherals

    // selector decode and pad-side selection per pad
    for (genvar g = 0; g < NP; g++) begin : g_pad
        localparam bit IS_DIO = (g == `PAFM_PAD_PORTA_LINE13);
        localparam bit IS_CLK = (g == `PAFM_PAD_PORTA_LINE14);
        assign idx_w[g]   = route(3'(g), sel_r[g]);                        // R03
        assign plain_w[g] = (sel_r[g] == `PAFM_SEL_PLAIN);                 // R05
        assign none_w[g]  = (idx_w[g] == `PAFM_IDX_NONE);
        // plain mode hands the pad to the port line, or to debug on the debug pads
        assign pad_out_nxt[g] = plain_w[g] ? (IS_DIO ? dbg_dio_out_i : (IS_CLK ? 1'b0 : gpio_out_i[g]))
                              : (none_w[g] ? 1'b0 : periph_out_i[idx_w[g]]); // R17 R18
        assign pad_oe_nxt[g]  = plain_w[g] ? (IS_DIO ? dbg_dio_oe_i : (IS_CLK ? 1'b0 : gpio_oe_i[g]))
                              : (none_w[g] ? 1'b0 : periph_oe_i[idx_w[g]]);  // R17 R18
        // debug pads keep their pull-up while they act as debug pins
        assign pad_pu_nxt[g]  = plain_w[g] ? ((IS_DIO || IS_CLK) ? 1'b1 : gpio_pu_i[g]) : 1'b0; // R02
    end

    // peripheral-side forwarding; the lowest pad wins when two pads pick one signal
    always_comb begin
        periph_in_nxt = '0;
        for (int p = NP - 1; p >= 0; p--) begin
            if (!plain_w[p] && !none_w[p]) begin
                periph_in_nxt[idx_w[p]] = pad_in_i[p];                    // R18
            end
        end
    end

    // selector registers: plain port line after reset, written per pad
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            sel_r <= {NP{`PAFM_SEL_RESET}};                                // R05 R06
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (sel_we_i[p]) begin
                    sel_r[p] <= sel_wdata_i[p*`PAFM_SEL_W +: `PAFM_SEL_W];  // R06
                end
            end
        end
    end

    // pad-side output flops; drivers off during reset
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pad_out_o <= '0;                                               // R01
            pad_oe_o  <= '0;                                               // R01
            pad_pu_o  <= '0;
        end else begin
            pad_out_o <= pad_out_nxt;
            pad_oe_o  <= pad_oe_nxt;
            pad_pu_o  <= pad_pu_nxt;
        end
    end

    // peripheral-side and port-side input flops
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            periph_in_o  <= '0;                                            // R01
            gpio_in_o    <= '0;
            dbg_dio_in_o <= 1'b1;
            dbg_clk_o    <= 1'b0;
        end else begin
            periph_in_o  <= periph_in_nxt;
            gpio_in_o    <= pad_in_i;
            // debug sees its pins only while they are in plain mode
            dbg_dio_in_o <= plain_w[`PAFM_PAD_PORTA_LINE13] ? pad_in_i[`PAFM_PAD_PORTA_LINE13] : 1'b1; // R02
            dbg_clk_o    <= plain_w[`PAFM_PAD_PORTA_LINE14] & pad_in_i[`PAFM_PAD_PORTA_LINE14];        // R02
        end
    end

    // analog switches, boot pad and radio aux line: none touch the selectors
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            analog_connect_o <= '0;
            boot_select_o    <= 1'b0;
            radio_aux_data_o <= 1'b0;
            radio_aux_out_o  <= 1'b0;
            radio_aux_oe_o   <= 1'b0;
        end else begin
            analog_connect_o <= analog_enable_i;                           // R04
            boot_select_o    <= boot_pad_i;                                // R15
            radio_aux_data_o <= radio_aux_dir_i ? 1'b0 : radio_aux_in_i;   // R16
            radio_aux_out_o  <= radio_aux_dir_i & radio_pa_enable_i;       // R16
            radio_aux_oe_o   <= radio_aux_dir_i;                           // R16
        end
    end

    // selector readback shows the live routing state
    assign sel_o = sel_r;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    property p_reset_hiz;
        $past(!nrst_i) |-> (pad_oe_o == '0) && (periph_in_o == '0);
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("pads not released after reset"); // R01

    property p_debug_pullup;
        (sel_r[`PAFM_PAD_PORTA_LINE13] == 3'h0) && (sel_r[`PAFM_PAD_PORTA_LINE14] == 3'h0) |=> pad_pu_o[3:2] == 2'b11;
    endproperty
    a_debug_pullup: assert property (p_debug_pullup) else $error("debug pad pull-up missing"); // R02

    property p_plain_gpio;
        (sel_r[`PAFM_PAD_PB8] == 3'h0) |=> pad_oe_o[`PAFM_PAD_PB8] == $past(gpio_oe_i[`PAFM_PAD_PB8]);
    endproperty
    a_plain_gpio: assert property (p_plain_gpio) else $error("plain port line not routed"); // R05

    property p_sel_write;
        sel_we_i[0] |=> sel_o[2:0] == $past(sel_wdata_i[2:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("selector write lost"); // R06

    property p_pa0_timer;
        (sel_r[`PAFM_PAD_PA0] == 3'h6) |=> (pad_out_o[0] == $past(periph_out_i[P_GT2_CH1]))
                                          && (pad_oe_o[0] == $past(periph_oe_i[P_GT2_CH1]));
    endproperty
    a_pa0_timer: assert property (p_pa0_timer) else $error("timer2 channel1 not on pad"); // R07

    property p_dio_unassigned;
        (sel_r[`PAFM_PAD_PORTA_LINE13] == 3'h1) |=> !pad_oe_o[`PAFM_PAD_PORTA_LINE13] && !pad_out_o[`PAFM_PAD_PORTA_LINE13];
    endproperty
    a_dio_unassigned: assert property (p_dio_unassigned) else $error("empty slot drives pad"); // R08

    property p_clk_twi;
        (sel_r[`PAFM_PAD_PORTA_LINE14] == 3'h2) |=> periph_in_o[P_TWI_SCL] == $past(pad_in_i[`PAFM_PAD_PORTA_LINE14]);
    endproperty
    a_clk_twi: assert property (p_clk_twi) else $error("two-wire clock not forwarded"); // R09

    property p_pb8_etr;
        (sel_r[`PAFM_PAD_PB8] == 3'h7) |=> pad_oe_o[`PAFM_PAD_PB8] == $past(periph_oe_i[P_ADV_ETR]);
    endproperty
    a_pb8_etr: assert property (p_pb8_etr) else $error("advanced timer trigger misrouted"); // R10

    property p_portc_line13_hz;
        (sel_r[`PAFM_PAD_PORTC_LINE13] == 3'h2) |=> pad_out_o[`PAFM_PAD_PORTC_LINE13] == $past(periph_out_i[P_ONE_HZ]);
    endproperty
    a_portc_line13_hz: assert property (p_portc_line13_hz) else $error("one-hertz output misrouted"); // R11

    // two empty slots, PA4 slot 3 and PF0 slot 7, are checked on their own pads, so one broken pad cannot hide behind the other
    property p_empty_slots;
        (sel_r[`PAFM_PAD_PA4] == 3'h3) |=> !pad_oe_o[`PAFM_PAD_PA4] && !pad_out_o[`PAFM_PAD_PA4];
    endproperty
    a_empty_slots: assert property (p_empty_slots) else $error("unassigned slot enabled driver"); // R17

    property p_pf0_empty;
        (sel_r[`PAFM_PAD_PF0] == 3'h7) |=> !pad_oe_o[`PAFM_PAD_PF0] && !pad_out_o[`PAFM_PAD_PF0];
    endproperty
    a_pf0_empty: assert property (p_pf0_empty) else $error("unassigned top slot enabled driver"); // R17

    property p_analog;
        sel_we_i[0] ##1 1'b1 |-> analog_connect_o == $past(analog_enable_i);
    endproperty
    a_analog: assert property (p_analog) else $error("analog switch follows selector"); // R04

    property p_radio_pa;
        radio_aux_dir_i && radio_pa_enable_i |=> radio_aux_oe_o && radio_aux_out_o;
    endproperty
    a_radio_pa: assert property (p_radio_pa) else $error("amplifier enable not driven"); // R16

    c_debug_mode:  cover property (plain_w[`PAFM_PAD_PORTA_LINE13] && dbg_dio_oe_i ##1 pad_oe_o[2]);
    c_portb_line12_lse:    cover property (sel_r[`PAFM_PAD_PORTB_LINE12] == 3'h3 ##1 pad_oe_o[`PAFM_PAD_PORTB_LINE12]);
    c_pf0_uart_rx: cover property (sel_r[`PAFM_PAD_PF0] == 3'h5 ##1 periph_in_o[P_S3_RX]);

endmodule

// File: tb/pafm_pad_model.sv
`timescale 1ns/100ps

// board side of the muxed pads: resolves each pad from the mux drive, an
// external driver, the pull-up, or a floating pattern
module pafm_pad_model (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] mux_data_i,
    input  wire logic [7:0] mux_oe_i,
    input  wire logic [7:0] mux_pu_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_lvl_i,
    output logic      [7:0] pad_lvl_o
);
    logic float_r;  // flips every cycle so a floating pad never reads stable

    // floating pattern; a released line must not keep its last value
    always_ff @(posedge ref_clk_i) begin
        float_r <= (float_r === 1'b1) ? 1'b0 : 1'b1;
    end

    // mux drive wins, then the external driver, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (mux_oe_i[i] === 1'b1) begin
                pad_lvl_o[i] = mux_data_i[i];
            end else if (ext_en_i[i]) begin
                pad_lvl_o[i] = ext_lvl_i[i];
            end else if (mux_pu_i[i] === 1'b1) begin
                pad_lvl_o[i] = 1'b1;
            end else begin
                pad_lvl_o[i] = float_r ^ i[0];
            end
        end
    end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps

module tb_top;
    import pafm_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [7:0]  sel_we_i = '0, gpio_out_i = '0, gpio_oe_i = '0, gpio_pu_i = '0;
    logic [7:0]  analog_enable_i = '0, ext_en = '0, ext_lvl = '0, pad_in_i;
    logic [23:0] sel_wdata_i = '0, sel_o;
    logic        dbg_dio_out_i = 1'b0, dbg_dio_oe_i = 1'b0, boot_pad_i = 1'b0;
    logic        radio_aux_in_i = 1'b0, radio_aux_dir_i = 1'b0, radio_pa_enable_i = 1'b0;
    logic [30:0] periph_out_i = '0, periph_oe_i = '0, periph_in_o;
    logic [7:0]  gpio_in_o, pad_out_o, pad_oe_o, pad_pu_o, analog_connect_o;
    logic        dbg_dio_in_o, dbg_clk_o, boot_select_o;
    logic        radio_aux_data_o, radio_aux_out_o, radio_aux_oe_o;
    int          n_fail = 0;
    int          checked = 0;
    // expected peripheral per pad and slot 1..7, straight from the slot maps
    pafm_periph_t slot_map [0:7][1:7] = '{
        '{P_S3_CTS, P_S2_CTS, P_TAMPER, P_CMP1, P_NONE, P_GT2_CH1, P_GT2_ETR},
        '{P_MON_CLK, P_S2_CTS, P_NONE, P_BUS_CLK, P_SPI_CS, P_GT2_ETR, P_ADV_CH2A},
        '{P_NONE, P_TWI_SDA, P_S1_RX, P_S2_TX, P_NONE, P_INFRARED_OUTPUT, P_NONE},
        '{P_S3_TX, P_TWI_SCL, P_S1_TX, P_S2_RX, P_NONE, P_NONE, P_NONE},
        '{P_TWI_SCL, P_S1_RX, P_S1_TX, P_NONE, P_NONE, P_GT1_CH3, P_ADV_ETR},
        '{P_GT2_TOGP, P_NONE, P_LSC_OUT, P_NONE, P_SPI_CS, P_GT1_TOGP, P_ADV_BRK},
        '{P_S1_TX, P_ONE_HZ, P_S1_CTS, P_CAL_EVT, P_BT_TRIG, P_NONE, P_TAMPER},
        '{P_WUT_TRIG, P_S3_TX, P_TWI_SDA, P_BT1_TOGN, P_S3_RX, P_GT2_TOGP, P_NONE}};

    // 10 MHz clock
    always #50 ref_clk_i = ~ref_clk_i;

    pafm_mux u_dut (
        .ref_clk_i         (ref_clk_i),
        .nrst_i            (nrst_i),
        .sel_we_i          (sel_we_i),
        .sel_wdata_i       (sel_wdata_i),
        .sel_o             (sel_o),
        .gpio_out_i        (gpio_out_i),
        .gpio_oe_i         (gpio_oe_i),
        .gpio_pu_i         (gpio_pu_i),
        .gpio_in_o         (gpio_in_o),
        .dbg_dio_out_i     (dbg_dio_out_i),
        .dbg_dio_oe_i      (dbg_dio_oe_i),
        .dbg_dio_in_o      (dbg_dio_in_o),
        .dbg_clk_o         (dbg_clk_o),
        .periph_out_i      (periph_out_i),
        .periph_oe_i       (periph_oe_i),
        .periph_in_o       (periph_in_o),
        .pad_in_i          (pad_in_i),
        .pad_out_o         (pad_out_o),
        .pad_oe_o          (pad_oe_o),
        .pad_pu_o          (pad_pu_o),
        .analog_enable_i   (analog_enable_i),
        .analog_connect_o  (analog_connect_o),
        .boot_pad_i        (boot_pad_i),
        .boot_select_o     (boot_select_o),
        .radio_aux_in_i    (radio_aux_in_i),
        .radio_aux_dir_i   (radio_aux_dir_i),
        .radio_pa_enable_i (radio_pa_enable_i),
        .radio_aux_data_o  (radio_aux_data_o),
        .radio_aux_out_o   (radio_aux_out_o),
        .radio_aux_oe_o    (radio_aux_oe_o)
    );

    pafm_pad_model u_pads (
        .ref_clk_i  (ref_clk_i),
        .mux_data_i (pad_out_o),
        .mux_oe_i   (pad_oe_o),
        .mux_pu_i   (pad_pu_o),
        .ext_en_i   (ext_en),
        .ext_lvl_i  (ext_lvl),
        .pad_lvl_o  (pad_in_i)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // registered paths chain through the pad model, so four cycles cover them
    task automatic settle;
        repeat (4) @(negedge ref_clk_i);
    endtask

    // one-cycle write of all eight selectors
    task automatic wr_sel(input logic [23:0] v);
        sel_we_i = 8'hff;
        sel_wdata_i = v;
        @(negedge ref_clk_i);
        sel_we_i = 8'h00;
        settle();
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        n_fail++;
        end_sim();
    end

    initial begin
        logic [23:0] sv;
        pafm_periph_t idx;
        logic none;
        repeat (2) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        settle();
        chk(sel_o, 24'h00_0000);
        chk(pad_oe_o, 8'h00);
        chk(pad_pu_o, 8'h0c);
        chk(periph_in_o, 31'h0000_0000);
        $display("test reset_state done");
        // plain mode: port line and debug pins pass through
        gpio_out_i = 8'h01;
        gpio_oe_i = 8'h01;
        gpio_pu_i = 8'h01;
        dbg_dio_out_i = 1'b1;
        dbg_dio_oe_i = 1'b1;
        ext_en = 8'h08;
        ext_lvl = 8'h08;
        settle();
        chk({pad_out_o[0], pad_oe_o[0], pad_pu_o[0]}, 3'b111);
        chk({pad_out_o[2], pad_oe_o[2], dbg_dio_in_o}, 3'b111);
        chk({pad_pu_o[3:2], dbg_clk_o, gpio_in_o[3]}, 4'b1111);
        gpio_oe_i = 8'h00;
        dbg_dio_oe_i = 1'b0;
        ext_en = 8'h00;
        gpio_pu_i = 8'hff;
        $display("test plain_mode done");
        // every slot of every pad, output then input direction
        for (int p = 0; p < 8; p++) begin
            for (int s = 1; s < 8; s++) begin
                idx = slot_map[p][s];
                none = (idx == P_NONE);
                sv = '0;
                sv[3*p +: 3] = s[2:0];
                periph_oe_i = '1;
                periph_out_i = none ? '1 : (31'h0000_0001 << idx);
                wr_sel(sv);
                chk(sel_o, sv);
                chk(pad_out_o[p], !none);
                chk(pad_oe_o[p], !none);
                chk(pad_pu_o[p], 1'b0);
                periph_oe_i = '0;
                periph_out_i = '0;
                ext_en[p] = 1'b1;
                ext_lvl[p] = 1'b1;
                settle();
                chk(periph_in_o, none ? '0 : (31'h0000_0001 << idx));
                if (p == 3) begin
                    chk(dbg_clk_o, 1'b0);
                end
                ext_en = 8'h00;
                ext_lvl = 8'h00;
            end
        end
        $display("test slot_maps done");
        // two pads on one peripheral input: lower pad index wins
        ext_en = 8'h03;
        ext_lvl = 8'h02;
        wr_sel(24'h00_0012);
        chk(periph_in_o[P_S2_CTS], 1'b0);
        ext_lvl = 8'h01;
        settle();
        chk(periph_in_o[P_S2_CTS], 1'b1);
        ext_en = 8'h00;
        $display("test shared_input done");
        // analog, boot and radio lines ignore the selectors, even across a selector write
        for (int k = 0; k < 2; k++) begin
            analog_enable_i = k ? 8'h5a : 8'ha5;
            boot_pad_i = k[0];
            radio_aux_in_i = 1'b1;
            radio_aux_dir_i = k[0];
            radio_pa_enable_i = 1'b1;
            wr_sel(k ? 24'hff_ffff : 24'h00_0000);
            chk(analog_connect_o, k ? 8'h5a : 8'ha5);
            chk(boot_select_o, k[0]);
            chk({radio_aux_data_o, radio_aux_out_o, radio_aux_oe_o}, k ? 3'b011 : 3'b100);
        end
        $display("test side_lines done");
        // reset in mid-run returns every pad to its plain function
        gpio_pu_i = 8'h00;
        @(negedge ref_clk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        settle();
        chk(sel_o, 24'h00_0000);
        chk(pad_pu_o, 8'h0c);
        chk(pad_oe_o, 8'h00);
        $display("test second_reset done");
        end_sim();
    end
endmodule
